// File: src/cosr_pkg.sv
// Package: register map, reset values and setpoint scales of the charge/output setpoint bank
// Notes on behaviour
// - Termination register: range bit plus five-bit code
// - Range 0: 500 uA plus code times 500 uA
// - Range 1: 6 mA plus code times 1 mA
// - Range 0 settings above 5 mA clamp to 5 mA
// - Bit 1 enables termination, resets to one
// - Termination suppressed unless CC or CV loop
// - External termination setting overrides register default
// - Battery code bits 7..1, reset 0x78
// - Battery target is 3.6 V plus code times 10 mV
// - Battery targets above 4.65 V clamp to 4.65 V
// - Top bit enables converter; off pulls output low
// - Range selector and level code set output voltage
// - Selector 01: 1.30 V plus code times 100 mV
// - Selector 11: 1.80 V plus code times 100 mV
// - Selector 00: lookup from 1.1 V to 2.333 V
// - Selector 10: lookup from 1.5 V to 2.75 V
// - Global reset bit restores defaults, reads zero
package cosr_pkg;
   // Register offsets
   localparam logic [7:0] CO_OFS_TERM  = 8'h04;
   localparam logic [7:0] CO_OFS_BATT  = 8'h05;
   localparam logic [7:0] CO_OFS_SYS   = 8'h06;
   localparam logic [7:0] CO_OFS_ILIM  = 8'h09;
   // Reset values
   localparam logic [7:0] CO_RST_TERM  = 8'h02;
   localparam logic [7:0] CO_RST_BATT  = 8'h78;
   localparam logic [7:0] CO_RST_SYS   = 8'h82;
   // Field positions
   localparam int CO_BIT_GLOBAL_RESET  = 7;
   localparam int CO_BIT_TERM_RANGE    = 7;
   localparam int CO_BIT_TERM_ENABLE   = 1;
   localparam int CO_BIT_SYS_ENABLE    = 7;
   // Setpoint scales, termination in uA, voltages in mV
   localparam logic [15:0] CO_TERM_LO_BASE_UA = 16'h01f4;   // 500 uA
   localparam logic [15:0] CO_TERM_LO_STEP_UA = 16'h01f4;   // 500 uA
   localparam logic [15:0] CO_TERM_LO_MAX_UA  = 16'h1388;   // 5 mA
   localparam logic [15:0] CO_TERM_HI_BASE_UA = 16'h1770;   // 6 mA
   localparam logic [15:0] CO_TERM_HI_STEP_UA = 16'h03e8;   // 1 mA
   localparam logic [15:0] CO_BATT_BASE_MV    = 16'h0e10;   // 3.6 V
   localparam logic [15:0] CO_BATT_STEP_MV    = 16'h000a;   // 10 mV
   localparam logic [15:0] CO_BATT_MAX_MV     = 16'h122a;   // 4.65 V
   localparam logic [15:0] CO_SYS_BASE01_MV   = 16'h0514;   // 1.30 V
   localparam logic [15:0] CO_SYS_BASE11_MV   = 16'h0708;   // 1.80 V
   localparam logic [15:0] CO_SYS_STEP_MV     = 16'h0064;   // 100 mV

   // Effective setpoints handed to the analog loops
   typedef struct packed {
      logic [15:0] term_current_ua;
      logic        term_active;
      logic [15:0] batt_reg_mv;
      logic        sys_converter_enable;
      logic [15:0] sys_out_mv;
   } cosr_setpoint_s;

   // Host register port
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } cosr_req_s;
endpackage : cosr_pkg

// File: src/cosr_regs.sv
// Module: three setpoint registers with clamped, decoded effective outputs
`timescale 1ns/1ns
module cosr_regs
(
   // Clock and reset
   input  wire logic               i_clk_sys,
   input  wire logic               i_resetn,
   // Register port from the serial control logic
   input  wire cosr_pkg::cosr_req_s i_req,
   output logic [7:0]              o_rdata,
   output logic                    o_rvalid,
   // Loop status and external termination override
   input  wire logic               i_cc_cv_in_control,
   input  wire logic               i_term_ext_valid,
   input  wire logic [15:0]        i_term_ext_ua,
   // Effective setpoints
   output cosr_pkg::cosr_setpoint_s o_setpoint
);
   import cosr_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Register storage
   logic [7:0]     term_reg;
   logic [7:0]     batt_reg;
   logic [7:0]     sys_reg;
   logic [7:0]     rdata_reg;
   logic           rvalid_reg;
   cosr_setpoint_s setpoint_reg;
   cosr_setpoint_s setpoint_next;

   ////////////////////////////////////////////////////////////////////////
   // Address decode
   wire wr_term   = i_req.wr && (i_req.addr == CO_OFS_TERM);
   wire wr_batt   = i_req.wr && (i_req.addr == CO_OFS_BATT);
   wire wr_sys    = i_req.wr && (i_req.addr == CO_OFS_SYS);
   // Global reset lives in the input-limit register, a write-only strobe
   wire glob_rst  = i_req.wr && (i_req.addr == CO_OFS_ILIM)
                    && i_req.wdata[CO_BIT_GLOBAL_RESET];
   // Bit 0 is never stored so it cannot steer anything
   wire [7:0] wmask = 8'hfe;

   // Read mux; the global reset bit always reads zero
   wire [7:0] rd_mux = (i_req.addr == CO_OFS_TERM) ? term_reg :
                       (i_req.addr == CO_OFS_BATT) ? batt_reg :
                       (i_req.addr == CO_OFS_SYS)  ? sys_reg  : 8'h00;

   ////////////////////////////////////////////////////////////////////////
   // Register writes; global reset wins over a simultaneous write
   always_ff @(posedge i_clk_sys or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         term_reg <= CO_RST_TERM;
         batt_reg <= CO_RST_BATT;
         sys_reg  <= CO_RST_SYS;
      end
      else if (glob_rst)
      begin
         term_reg <= CO_RST_TERM;
         batt_reg <= CO_RST_BATT;
         sys_reg  <= CO_RST_SYS;
      end
      else
      begin
         if (wr_term)
            term_reg <= i_req.wdata & wmask;
         if (wr_batt)
            batt_reg <= i_req.wdata & wmask;
         if (wr_sys)
            sys_reg <= i_req.wdata & wmask;
      end
   end

   // Read data, one cycle after the strobe
   always_ff @(posedge i_clk_sys or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         rdata_reg  <= 8'h00;
         rvalid_reg <= 1'b0;
      end
      else
      begin
         rdata_reg  <= i_req.rd ? rd_mux : 8'h00;
         rvalid_reg <= i_req.rd;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Termination current decode
   wire        term_range = term_reg[CO_BIT_TERM_RANGE];
   wire [4:0]  term_code  = term_reg[6:2];
   wire [15:0] term_lo    = CO_TERM_LO_BASE_UA
                            + 16'(term_code) * CO_TERM_LO_STEP_UA;
   wire [15:0] term_lo_cl = (term_lo > CO_TERM_LO_MAX_UA) ?
                            CO_TERM_LO_MAX_UA : term_lo;
   wire [15:0] term_hi    = CO_TERM_HI_BASE_UA
                            + 16'(term_code) * CO_TERM_HI_STEP_UA;
   wire [15:0] term_reg_ua = term_range ? term_hi : term_lo_cl;
   // External setting replaces the register value while it is present
   wire [15:0] term_eff   = i_term_ext_valid ? i_term_ext_ua : term_reg_ua;
   // Other loops (input-voltage, cool reduction) block termination
   wire term_act = term_reg[CO_BIT_TERM_ENABLE] && i_cc_cv_in_control;

   ////////////////////////////////////////////////////////////////////////
   // Battery regulation target decode
   wire [6:0]  batt_reg_code = batt_reg[7:1];
   wire [15:0] batt_raw = CO_BATT_BASE_MV + 16'(batt_reg_code) * CO_BATT_STEP_MV;
   wire [15:0] batt_eff = (batt_raw > CO_BATT_MAX_MV) ? CO_BATT_MAX_MV : batt_raw;

   ////////////////////////////////////////////////////////////////////////
   // System output level decode
   wire [1:0]  sys_range_select = sys_reg[6:5];
   wire [3:0]  sys_level_code   = sys_reg[4:1];
   wire [15:0] sys_lin = 16'(sys_level_code) * CO_SYS_STEP_MV;

   // Lookup band starting 1.1 V; the 83 mV steps round to the printed mV
   function automatic logic [15:0] cosr_lut00(input logic [3:0] c);
      case (c)
         4'h0: cosr_lut00 = 16'd1100;
         4'h1: cosr_lut00 = 16'd1200;
         4'h2: cosr_lut00 = 16'd1250;
         4'h3: cosr_lut00 = 16'd1333;
         4'h4: cosr_lut00 = 16'd1417;
         4'h5: cosr_lut00 = 16'd1500;
         4'h6: cosr_lut00 = 16'd1583;
         4'h7: cosr_lut00 = 16'd1667;
         4'h8: cosr_lut00 = 16'd1750;
         4'h9: cosr_lut00 = 16'd1833;
         4'ha: cosr_lut00 = 16'd1917;
         4'hb: cosr_lut00 = 16'd2000;
         4'hc: cosr_lut00 = 16'd2083;
         4'hd: cosr_lut00 = 16'd2167;
         4'he: cosr_lut00 = 16'd2250;
         default: cosr_lut00 = 16'd2333;
      endcase
   endfunction : cosr_lut00

   // Lookup band from 1.5 V: codes 0 to 10 are the 00 table shifted by five entries
   function automatic logic [15:0] cosr_lut10(input logic [3:0] c);
      case (c)
         4'hb: cosr_lut10 = 16'd2417;
         4'hc: cosr_lut10 = 16'd2500;
         4'hd: cosr_lut10 = 16'd2583;
         4'he: cosr_lut10 = 16'd2667;
         4'hf: cosr_lut10 = 16'd2750;
         default: cosr_lut10 = cosr_lut00(4'(c + 4'h5));
      endcase
   endfunction : cosr_lut10

   wire [15:0] sys_mv = (sys_range_select == 2'b00) ? cosr_lut00(sys_level_code) :
                        (sys_range_select == 2'b01) ? CO_SYS_BASE01_MV + sys_lin :
                        (sys_range_select == 2'b10) ? cosr_lut10(sys_level_code) :
                                                      CO_SYS_BASE11_MV + sys_lin;
   wire sys_en = sys_reg[CO_BIT_SYS_ENABLE];
   // Disabled converter reports 0 mV: output pulled low
   wire [15:0] sys_eff = sys_en ? sys_mv : 16'h0000;

   ////////////////////////////////////////////////////////////////////////
   // Registered setpoints keep every output straight from a flop
   always_comb
   begin
      setpoint_next.term_current_ua      = term_eff;
      setpoint_next.term_active          = term_act;
      setpoint_next.batt_reg_mv          = batt_eff;
      setpoint_next.sys_converter_enable = sys_en;
      setpoint_next.sys_out_mv           = sys_eff;
   end

   always_ff @(posedge i_clk_sys or negedge i_resetn)
   begin
      if (!i_resetn)
         setpoint_reg <= '0;
      else
         setpoint_reg <= setpoint_next;
   end

   assign o_rdata    = rdata_reg;
   assign o_rvalid   = rvalid_reg;
   assign o_setpoint = setpoint_reg;
endmodule : cosr_regs

// File: test/cosr_regs_checker.sv
// Checker: port timing and value relations of the setpoint bank
`timescale 1ns/1ns
module cosr_regs_checker
(
   // Clock and reset
   input wire logic                     i_clk_sys,
   input wire logic                     i_resetn,
   // Register port, loop status and setpoints
   input wire cosr_pkg::cosr_req_s      i_req,
   input wire logic [7:0]               o_rdata,
   input wire logic                     o_rvalid,
   input wire logic                     i_cc_cv_in_control,
   input wire logic                     i_term_ext_valid,
   input wire logic [15:0]              i_term_ext_ua,
   input wire cosr_pkg::cosr_setpoint_s o_setpoint
);
   import cosr_pkg::*;
   ////////////////////////////////////////////////////////////
   // One domain; $past is guarded so pre-reset samples never count
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_resetn);
   chk_read_valid: assert property ($past(i_resetn) |-> o_rvalid == $past(i_req.rd))
      else $error("read valid not tied to read strobe");
   chk_read_spare: assert property (i_req.rd |=> o_rdata[0] == 1'b0)
      else $error("spare bit read back set");
   chk_idle_rdata: assert property (!o_rvalid |-> o_rdata == 8'h00)
      else $error("read data not zero outside reads");
   chk_reset_bit: assert property (
      i_req.rd && i_req.addr == CO_OFS_ILIM |=> o_rdata == 8'h00)
      else $error("global reset bit read as set");
   chk_term_gate: assert property (
      $past(i_resetn) && !$past(i_cc_cv_in_control) |-> !o_setpoint.term_active)
      else $error("termination active outside CC/CV");
   chk_ext_override: assert property (
      $past(i_resetn) && $past(i_term_ext_valid)
      |-> o_setpoint.term_current_ua == $past(i_term_ext_ua))
      else $error("override lost");
   chk_batt_ceiling: assert property (o_setpoint.batt_reg_mv <= CO_BATT_MAX_MV)
      else $error("battery target above ceiling");
   chk_sys_off: assert property (
      !o_setpoint.sys_converter_enable |-> o_setpoint.sys_out_mv == 16'h0000)
      else $error("disabled output not zero");
   chk_sys_enable: assert property (
      i_req.wr && i_req.addr == CO_OFS_SYS |-> ##2
      o_setpoint.sys_converter_enable == $past(i_req.wdata[CO_BIT_SYS_ENABLE], 2))
      else $error("enable late");
   // Defaults decode to 4200 mV battery and 1200 mV output two edges on
   chk_global_reset: assert property (
      i_req.wr && i_req.addr == CO_OFS_ILIM && i_req.wdata[CO_BIT_GLOBAL_RESET] |-> ##2
      o_setpoint.batt_reg_mv == 16'h1068 && o_setpoint.sys_out_mv == 16'h04b0)
      else $error("setpoints not back at defaults");
endmodule : cosr_regs_checker
bind cosr_regs cosr_regs_checker i_chk (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_req(i_req),
   .o_rdata(o_rdata), .o_rvalid(o_rvalid), .i_cc_cv_in_control(i_cc_cv_in_control),
   .i_term_ext_valid(i_term_ext_valid), .i_term_ext_ua(i_term_ext_ua), .o_setpoint(o_setpoint));

// File: test/testbench.sv
// Testbench: directed and random register traffic against a bench model
`timescale 1ns/1ns
module testbench;
   import cosr_pkg::*;
   logic           i_clk_sys    = 1'b0;
   logic           i_resetn     = 1'b0;
   cosr_req_s      i_req        = '0;
   logic           cc_cv        = 1'b1;
   logic           ext_v        = 1'b0;
   logic [15:0]    ext_ua       = 16'h0000;
   logic [7:0]     o_rdata;
   logic           o_rvalid;
   cosr_setpoint_s o_setpoint;
   logic [7:0]     m_term;
   logic [7:0]     m_batt;
   logic [7:0]     m_sys;
   logic [15:0]    tbl [9]      = '{16'h0424, 16'h0428, 16'h04fe, 16'h0400, 16'h05d2,
                                    16'h05d4, 16'h05ff, 16'h0600, 16'h0980};
   int             mismatches   = 0;
   int             total_checks = 0;
   ////////////////////////////////////////////////////////////
   // 25 MHz clock
   always #20 i_clk_sys = ~i_clk_sys;
   cosr_regs i_dut (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_req(i_req),
      .o_rdata(o_rdata), .o_rvalid(o_rvalid), .i_cc_cv_in_control(cc_cv),
      .i_term_ext_valid(ext_v), .i_term_ext_ua(ext_ua), .o_setpoint(o_setpoint));
   // Verdict, shared by the main sequence and the watchdog
   task automatic give_verdict();
      $display("Checks %0d, mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : give_verdict
   // Compare of setpoint bundles
   task automatic chk_sp(cosr_setpoint_s got, cosr_setpoint_s exp);
      total_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_sp
   // Compare of read bytes
   task automatic chk_byte(logic [7:0] got, logic [7:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_byte
   // Expected setpoints from the register model and loop inputs
   function automatic cosr_setpoint_s model_sp();
      cosr_setpoint_s e;
      int c;
      int v;
      c = m_term[6:2];
      v = m_term[7] ? 6000 + c * 1000 : 500 + c * 500;
      if (!m_term[7] && v > 5000)
         v = 5000;
      e.term_current_ua = ext_v ? ext_ua : 16'(v);
      e.term_active = m_term[1] & cc_cv;
      v = 3600 + m_batt[7:1] * 10;
      e.batt_reg_mv = 16'(v > 4650 ? 4650 : v);
      c = m_sys[4:1];
      case (m_sys[6:5])
         2'b00: v = c < 2 ? 1100 + c * 100 : 1250 + ((c - 2) * 250 + 1) / 3;
         2'b01: v = 1300 + c * 100;
         2'b10: v = 1500 + (c * 250 + 1) / 3;
         default: v = 1800 + c * 100;
      endcase
      e.sys_converter_enable = m_sys[7];
      e.sys_out_mv = m_sys[7] ? 16'(v) : 16'h0000;
      return e;
   endfunction : model_sp
   // One cycle; expectations use the state before the edge, so reads see old data
   task automatic step(logic wr, logic rd, logic [7:0] a, logic [7:0] d);
      cosr_setpoint_s e;
      logic [7:0] r;
      i_req = '{wr, rd, a, d};
      e = model_sp();
      r = !rd ? 8'h00 : a == CO_OFS_TERM ? m_term : a == CO_OFS_BATT ? m_batt
        : a == CO_OFS_SYS ? m_sys : 8'h00;
      if (wr && a == CO_OFS_ILIM && d[7])
         {m_term, m_batt, m_sys} = {CO_RST_TERM, CO_RST_BATT, CO_RST_SYS};
      m_term = wr && a == CO_OFS_TERM ? d & 8'hfe : m_term;
      m_batt = wr && a == CO_OFS_BATT ? d & 8'hfe : m_batt;
      m_sys = wr && a == CO_OFS_SYS ? d & 8'hfe : m_sys;
      @(posedge i_clk_sys);
      #1;
      chk_sp(o_setpoint, e);
      chk_byte(o_rdata, r);
      chk_byte({7'h00, o_rvalid}, {7'h00, rd});
   endtask : step
   // Main sequence
   initial
   begin
      void'($urandom(74));
      {m_term, m_batt, m_sys} = {CO_RST_TERM, CO_RST_BATT, CO_RST_SYS};
      repeat (12) @(posedge i_clk_sys);
      #1;
      i_resetn = 1'b1;
      for (int a = 4; a < 11; a++)
         step(1'b0, 1'b1, 8'(a), 8'h00);
      $display("Reset value test done");
      for (int i = 0; i < 9; i++)
      begin
         step(1'b1, 1'b0, tbl[i][15:8], tbl[i][7:0]);
         step(1'b0, 1'b1, tbl[i][15:8], 8'h00);
      end
      $display("Clamp and global reset test done");
      for (int j = 0; j < 128; j++)
         step(1'b1, 1'b0, CO_OFS_SYS, 8'(j * 2));
      $display("Output level sweep done");
      for (int n = 0; n < 3000; n++)
      begin
         cc_cv = 1'($urandom);
         ext_v = $urandom_range(0, 7) == 0;
         ext_ua = 16'($urandom);
         step(1'($urandom), 1'($urandom), 8'(4 + $urandom_range(0, 5)), 8'($urandom));
      end
      $display("Random traffic test done");
      give_verdict();
   end
   // Watchdog at about three times the expected run
   initial
   begin
      #400000;
      mismatches++;
      give_verdict();
   end
endmodule : testbench
